// *** design/ede_pkg.sv ***
// shared constants and types for the endpoint auto-dma block
package ede_pkg;

  // ----------------------------------------------------------------
  // register map
  // ----------------------------------------------------------------
  localparam int         EDE_AW       = 2;
  localparam logic [1:0] EDE_OFS_CTRL = 2'h0;
  localparam logic [1:0] EDE_OFS_EVT  = 2'h1;
  localparam logic [1:0] EDE_OFS_CNT  = 2'h2;
  localparam logic [1:0] EDE_OFS_ERR  = 2'h3;

  // transfer_control fields
  localparam int EDE_CT_EN   = 7;
  localparam int EDE_CT_IGN  = 6;
  localparam int EDE_CT_TGL  = 5;
  localparam int EDE_CT_AUTO = 4;
  localparam int EDE_CT_TIM  = 3;
  localparam int EDE_CT_SEL  = 0;

  // transfer_events fields
  localparam int EDE_EV_HALT = 0;
  localparam int EDE_EV_ERR  = 1;
  localparam int EDE_EV_CNT  = 2;
  localparam int EDE_EV_SHRT = 3;
  localparam int EDE_EV_NEXT_TOGGLE_STATE = 5;

  // error register fields
  localparam int EDE_ER_AEH = 7;

  // endpoint select codes above this are reserved
  localparam logic [2:0] EDE_SEL_MAX = 3'h5;
  localparam int         EDE_NUM_EP  = 6;

  // ----------------------------------------------------------------
  // types
  // ----------------------------------------------------------------
  typedef enum logic [4:0] {
    EDE_IDLE    = 5'h01,
    EDE_RX_WAIT = 5'h02,
    EDE_RX_DMA  = 5'h04,
    EDE_TX_DMA  = 5'h08,
    EDE_TX_WAIT = 5'h10
  } ede_state_t;

  typedef struct packed {
    logic [EDE_AW-1:0] addr;
    logic [7:0]        wdata;
    logic              wr;
    logic              rd;
  } ede_bus_t;

  // per-endpoint levels, bit 0 is endpoint one
  typedef struct packed {
    logic [EDE_NUM_EP-1:0] tx_done;
    logic [EDE_NUM_EP-1:0] rx_last;
    logic [EDE_NUM_EP-1:0] warn;
    logic [EDE_NUM_EP-1:0] empty;
  } ede_ep_lvl_t;

  // one-cycle events concerning the selected endpoint
  typedef struct packed {
    logic stat_rd;
    logic txlast_set;
    logic fifo_acc;
    logic reg_acc;
    logic pkt_done;
    logic pkt_err;
    logic pkt_tgl;
    logic pkt_short;
    logic dma_done;
  } ede_ep_evt_t;

  typedef struct packed {
    logic       en;
    logic       ign;
    logic       itgl;
    logic       auto_m;
    logic       tim;
    logic [2:0] sel;
    logic       halt;
    logic       err;
    logic       cnt;
    logic       shrt;
    logic       next_toggle_state;
    logic       short_pend;
    logic [7:0] pcount;
    logic       auto_error_handling;
    logic [6:0] epreset;
    logic [6:0] ecount;
    ede_state_t st;
    logic       drain;
    logic [1:0] msync;
    logic       cpl;
    logic       cpl_prev;
    logic       req;
    logic       flush;
    logic       rx_en;
    logic       tx_en;
    logic [7:0] rdata;
  } ede_regs_t;

  localparam ede_regs_t EDE_REGS_RST = '{st: EDE_IDLE, default: '0};

endpackage

// *** design/ede_auto_dma.sv ***
// endpoint dma request and automatic packet transfer engine
//
// Contract
// RULE1 - three-bit select picks endpoint one to six; codes 11x select none
// RULE2 - completion timing: request on transmit complete or receive last
// RULE3 - warning timing: request while selected fifo warning is set
// RULE4 - transmit request holds until status read, last set, or warning ends
// RULE5 - receive request holds until status read, fifo empty, or warning ends
// RULE6 - starting automatic mode enables endpoint and flushes its fifo
// RULE7 - firmware clears enable and events before starting automatic mode
// RULE8 - any event bit except toggle ends automatic mode
// RULE9 - auto receive: packet then dma; auto transmit: dma then send
// RULE10 - auto and enable cleared together stop at once, else finish first
// RULE11 - initial toggle write also loads next toggle state
// RULE12 - receive toggle mismatch stops auto mode unless ignore bit set
// RULE13 - enable turns dma on; clearing it terminates dma
// RULE14 - serial interface mode pin blocks setting enable
// RULE15 - four low event flags stay visible until firmware clears them
// RULE16 - auto cleared with enable kept: finish, go idle, then halt flag
// RULE17 - clearing enable stops dma and sets halt flag at once
// RULE18 - firmware fifo access during dma halts dma and sets halt flag
// RULE19 - endpoint register access in auto mode halts dma, sets halt flag
// RULE20 - error flag on failed packet or toggle mismatch before update
// RULE21 - with auto error handling, error flag only after retries run out
// RULE22 - count-done flag set when packet count already zero
// RULE23 - next toggle inverts per good packet; toggle write wins
// RULE24 - packet count decrements without underflow; write wins
// RULE25 - request output is a registered level of its condition
//
// The plain strobed port and the address map were chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none

module ede_auto_dma (
  // clock and reset
  input  wire logic                 clk_sys_i,
  input  wire logic                 srst_i,
  // register port
  input  wire ede_pkg::ede_bus_t    bus_i,
  output logic [7:0]                rdata_o,
  // endpoint side
  input  wire ede_pkg::ede_ep_lvl_t ep_lvl_i,
  input  wire ede_pkg::ede_ep_evt_t ep_evt_i,
  input  wire logic                 interface_mode_pin_i,
  output logic                      flush_o,
  output logic                      ep_auto_enable_o,
  output logic                      rx_enable_o,
  output logic                      tx_enable_o,
  output logic                      next_toggle_state_o,
  output logic [3:0]                event_flags_o,
  // dma controller side
  output logic                      dma_req_o
);
  import ede_pkg::*;

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  function automatic logic ede_pick(input logic [5:0] v,
                                    input logic [2:0] s);
    ede_pick = 1'b0;
    if (s <= EDE_SEL_MAX) begin // [RULE1]
      ede_pick = v[s];
    end
  endfunction

  function automatic logic ede_is_tx(input logic [2:0] s);
    ede_is_tx = ~s[0]; // odd endpoints transmit [RULE1]
  endfunction

  ede_regs_t r;
  ede_regs_t n;

  logic sel_ok, tx_ep, done_sel, last_sel, warn_sel, empty_sel;
  logic cpl_lvl, cpl_clr, warn_req, req_cond;
  logic wr_ctl, wr_evt, wr_cnt, wr_err;
  logic evt_any, rx_bad, tx_bad, fw_stop, op_ok, op_err;

  assign sel_ok    = (r.sel <= EDE_SEL_MAX);
  assign tx_ep     = ede_is_tx(r.sel);
  assign done_sel  = ede_pick(ep_lvl_i.tx_done, r.sel);
  assign last_sel  = ede_pick(ep_lvl_i.rx_last, r.sel);
  assign warn_sel  = ede_pick(ep_lvl_i.warn, r.sel);
  assign empty_sel = ede_pick(ep_lvl_i.empty, r.sel);

  assign wr_ctl = bus_i.wr & (bus_i.addr == EDE_OFS_CTRL);
  assign wr_evt = bus_i.wr & (bus_i.addr == EDE_OFS_EVT);
  assign wr_cnt = bus_i.wr & (bus_i.addr == EDE_OFS_CNT);
  assign wr_err = bus_i.wr & (bus_i.addr == EDE_OFS_ERR);

  // ----------------------------------------------------------------
  // request conditions
  // ----------------------------------------------------------------
  assign cpl_lvl = tx_ep ? done_sel : last_sel; // [RULE2]
  // completion request ends on status read, last set or empty fifo
  assign cpl_clr = ep_evt_i.stat_rd |
                   (tx_ep ? ep_evt_i.txlast_set : empty_sel); // [RULE4] [RULE5]
  // warning request ends with the warning or on done / empty
  assign warn_req = warn_sel & ~(tx_ep ? done_sel : empty_sel); // [RULE3]

  always_comb begin
    req_cond = 1'b0;
    if (r.en & sel_ok) begin // [RULE13]
      if (r.st == EDE_RX_DMA) begin
        req_cond = r.cpl; // [RULE9]
      end else if (r.st == EDE_TX_DMA) begin
        req_cond = 1'b1; // [RULE9]
      end else if (!(r.auto_m | r.drain)) begin
        req_cond = r.tim ? warn_req : r.cpl; // [RULE2] [RULE3]
      end
    end
  end

  assign evt_any = r.halt | r.err | r.cnt | r.shrt;
  assign rx_bad  = ep_evt_i.pkt_err |
                   ((ep_evt_i.pkt_tgl != r.next_toggle_state) & ~r.ign); // [RULE12] [RULE20]
  assign tx_bad  = ep_evt_i.pkt_err | (ep_evt_i.pkt_tgl != r.next_toggle_state); // [RULE20]
  assign fw_stop = (ep_evt_i.fifo_acc & r.en) |
                   (ep_evt_i.reg_acc & r.en & r.auto_m);

  // ----------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------
  always_comb begin
    n      = r;
    op_ok  = 1'b0;
    op_err = 1'b0;
    n.msync = {r.msync[0], interface_mode_pin_i};
    n.flush = 1'b0;
    n.rdata = 8'h00;

    // write-one-to-clear; hardware sets below win over these
    if (wr_evt) begin
      n.halt = r.halt & ~bus_i.wdata[EDE_EV_HALT]; // [RULE15]
      n.err  = r.err & ~bus_i.wdata[EDE_EV_ERR];
      n.cnt  = r.cnt & ~bus_i.wdata[EDE_EV_CNT];
      n.shrt = r.shrt & ~bus_i.wdata[EDE_EV_SHRT];
    end

    // completion latch; a fresh edge beats a same-cycle clear
    n.cpl_prev = cpl_lvl;
    if (cpl_clr) begin
      n.cpl = 1'b0; // [RULE4] [RULE5]
    end
    if (cpl_lvl & ~r.cpl_prev) begin
      n.cpl = 1'b1; // [RULE2]
    end

    unique case (r.st)
      EDE_IDLE: begin
        if (r.drain) begin
          n.drain = 1'b0;
          n.halt  = 1'b1; // [RULE16]
        end else if (r.en & r.auto_m & sel_ok) begin
          n.st = tx_ep ? EDE_TX_DMA : EDE_RX_WAIT; // [RULE9]
        end
      end
      EDE_RX_WAIT: begin
        if (r.drain) begin
          // nothing received yet, so nothing left to finish
          n.st    = EDE_IDLE;
          n.drain = 1'b0;
          n.halt  = 1'b1; // [RULE16]
        end else if (ep_evt_i.pkt_done) begin
          if (rx_bad) begin
            op_err = 1'b1; // [RULE12]
          end else begin
            n.next_toggle_state       = ~r.next_toggle_state; // [RULE23]
            n.short_pend = ep_evt_i.pkt_short;
            n.st         = EDE_RX_DMA; // [RULE9]
          end
        end
      end
      EDE_RX_DMA: begin
        if (ep_evt_i.dma_done) begin
          op_ok = 1'b1;
          // short packet reported once it sits in memory
          n.shrt = n.shrt | r.short_pend;
          n.st   = EDE_RX_WAIT;
        end
      end
      EDE_TX_DMA: begin
        if (ep_evt_i.dma_done) begin
          n.st = EDE_TX_WAIT; // [RULE9]
        end
      end
      EDE_TX_WAIT: begin
        if (ep_evt_i.pkt_done) begin
          if (tx_bad) begin
            op_err = 1'b1; // [RULE20]
          end else begin
            n.next_toggle_state = ~r.next_toggle_state; // [RULE23]
            op_ok  = 1'b1;
            n.st   = EDE_TX_DMA;
          end
        end
      end
      default: begin
        n.st = EDE_IDLE;
      end
    endcase

    if (op_ok) begin
      n.ecount = r.epreset;
      if (r.pcount == 8'h00) begin
        n.cnt = 1'b1; // [RULE22]
      end else begin
        n.pcount = r.pcount - 8'h01; // [RULE24]
      end
      if (r.drain) begin
        n.st    = EDE_IDLE;
        n.drain = 1'b0;
        n.halt  = 1'b1; // [RULE16]
      end
    end

    if (op_err) begin
      if (r.auto_error_handling & (r.ecount != 7'h00)) begin
        // retry: drop the packet and run it again
        n.ecount = r.ecount - 7'h01; // [RULE21]
        n.flush  = 1'b1;
        n.st     = tx_ep ? EDE_TX_DMA : EDE_RX_WAIT;
      end else begin
        n.err = 1'b1; // [RULE20] [RULE21]
      end
    end

    if (wr_cnt) begin
      n.pcount = bus_i.wdata; // [RULE24]
    end

    // preset is locked while the engine runs
    if (wr_err & ~(r.auto_m | r.drain)) begin
      n.auto_error_handling     = bus_i.wdata[EDE_ER_AEH];
      n.epreset = bus_i.wdata[6:0];
    end

    if (wr_ctl) begin
      n.sel  = bus_i.wdata[EDE_CT_SEL +: 3]; // [RULE1]
      n.tim  = bus_i.wdata[EDE_CT_TIM];
      n.ign  = bus_i.wdata[EDE_CT_IGN];
      n.itgl = bus_i.wdata[EDE_CT_TGL];
      n.next_toggle_state = bus_i.wdata[EDE_CT_TGL]; // [RULE11] [RULE23]
      n.en   = bus_i.wdata[EDE_CT_EN] & ~r.msync[1]; // [RULE13] [RULE14]
      if (bus_i.wdata[EDE_CT_AUTO] & ~r.auto_m & ~r.en & ~evt_any) begin
        n.auto_m = 1'b1; // [RULE7]
        n.flush  = 1'b1; // [RULE6]
      end else if (~bus_i.wdata[EDE_CT_AUTO] & r.auto_m) begin
        n.auto_m = 1'b0;
        n.drain  = n.en; // [RULE10] [RULE16]
      end
      if (r.en & ~n.en) begin
        n.st    = EDE_IDLE; // [RULE10]
        n.drain = 1'b0;
        n.halt  = 1'b1; // [RULE17]
      end
    end

    // firmware touching the fifo or endpoint registers mid-transfer
    if (fw_stop) begin
      n.en     = 1'b0;
      n.auto_m = 1'b0;
      n.drain  = 1'b0;
      n.st     = EDE_IDLE;
      n.halt   = 1'b1; // [RULE18] [RULE19]
    end

    if (n.halt | n.err | n.cnt | n.shrt) begin
      n.auto_m = 1'b0; // [RULE8]
      n.drain  = 1'b0;
      n.st     = EDE_IDLE;
    end

    if (~n.auto_m & ~n.drain) begin
      n.ecount = n.epreset;
    end

    n.req   = req_cond; // [RULE25]
    n.rx_en = (n.st == EDE_RX_WAIT); // [RULE6] [RULE9]
    n.tx_en = (n.st == EDE_TX_WAIT); // [RULE9]

    if (bus_i.rd) begin
      unique case (bus_i.addr)
        EDE_OFS_CTRL: n.rdata = {r.en, r.ign, r.itgl, r.auto_m, r.tim, r.sel};
        EDE_OFS_EVT:  n.rdata = {2'b00, r.next_toggle_state, 1'b0,
                                 r.shrt, r.cnt, r.err, r.halt};
        EDE_OFS_CNT:  n.rdata = r.pcount;
        EDE_OFS_ERR:  n.rdata = {r.auto_error_handling,
                                 (r.auto_m | r.drain) ? r.ecount : r.epreset};
      endcase
    end
  end

  always_ff @(posedge clk_sys_i) begin
    if (srst_i) begin
      r <= EDE_REGS_RST;
    end else begin
      r <= n;
    end
  end

  // ----------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------
  assign rdata_o             = r.rdata;
  assign dma_req_o           = r.req;
  assign flush_o             = r.flush;
  assign ep_auto_enable_o    = r.auto_m;
  assign rx_enable_o         = r.rx_en;
  assign tx_enable_o         = r.tx_en;
  assign next_toggle_state_o = r.next_toggle_state;
  assign event_flags_o       = {r.shrt, r.cnt, r.err, r.halt}; // [RULE15]

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge clk_sys_i); endclocking
  default disable iff (srst_i);

  logic quiet;
  assign quiet = ~wr_ctl & ~ep_evt_i.fifo_acc & ~ep_evt_i.reg_acc;

  sequence s_auto_start;
    wr_ctl & bus_i.wdata[EDE_CT_AUTO] & ~r.auto_m & ~r.en & ~evt_any;
  endsequence

  sequence s_rx_toggle_bad;
    (r.st == EDE_RX_WAIT) & r.auto_m & r.en & quiet & ep_evt_i.pkt_done
      & ~ep_evt_i.pkt_err & (ep_evt_i.pkt_tgl != r.next_toggle_state) & ~r.ign & ~r.auto_error_handling;
  endsequence

  sequence s_tx_retry;
    (r.st == EDE_TX_WAIT) & r.auto_m & r.en & quiet & ep_evt_i.pkt_done
      & ep_evt_i.pkt_err & r.auto_error_handling & (r.ecount != 7'h00) & ~evt_any;
  endsequence

  sequence s_drain_end;
    (r.st == EDE_RX_DMA) & r.drain & r.en & quiet & ep_evt_i.dma_done;
  endsequence

  property p_no_req_off;
    !r.en |=> !dma_req_o;
  endproperty
  a_no_req_off: assert property (p_no_req_off) // [RULE13]
    else $error("dma request while transfer disabled");

  property p_serial_block;
    (wr_ctl & bus_i.wdata[EDE_CT_EN] & r.msync[1]) |=> !r.en;
  endproperty
  a_serial_block: assert property (p_serial_block) // [RULE14]
    else $error("enable set in serial interface mode");

  property p_en_clear_halt;
    (r.en & wr_ctl & !bus_i.wdata[EDE_CT_EN])
      |=> r.halt & (r.st == EDE_IDLE) ##1 !dma_req_o;
  endproperty
  a_en_clear_halt: assert property (p_en_clear_halt) // [RULE17]
    else $error("enable clear did not halt at once");

  property p_toggle_load;
    wr_ctl |=> (r.next_toggle_state == $past(bus_i.wdata[EDE_CT_TGL]));
  endproperty
  a_toggle_load: assert property (p_toggle_load) // [RULE11]
    else $error("toggle write not loaded into next toggle");

  property p_event_ends_auto;
    (r.halt | r.err | r.cnt | r.shrt) |-> !r.auto_m & (r.st == EDE_IDLE);
  endproperty
  a_event_ends_auto: assert property (p_event_ends_auto) // [RULE8]
    else $error("auto mode alive with event pending");

  property p_rx_toggle_stop;
    s_rx_toggle_bad |=> r.err & !r.auto_m & (r.st == EDE_IDLE);
  endproperty
  a_rx_toggle_stop: assert property (p_rx_toggle_stop) // [RULE12]
    else $error("toggle mismatch did not stop auto mode");

  property p_count_dec;
    ((r.st == EDE_RX_DMA) & ep_evt_i.dma_done & (r.pcount != 8'h00)
      & !wr_cnt) |=> (r.pcount == $past(r.pcount) - 8'h01);
  endproperty
  a_count_dec: assert property (p_count_dec) // [RULE24]
    else $error("packet count did not decrement by one");

  property p_count_done;
    ((r.st == EDE_RX_DMA) & ep_evt_i.dma_done & (r.pcount == 8'h00)
      & !wr_cnt) |=> r.cnt & (r.pcount == 8'h00);
  endproperty
  a_count_done: assert property (p_count_done) // [RULE22]
    else $error("count-done not set at zero count");

  property p_auto_start;
    s_auto_start |=> flush_o & r.auto_m ##1 !flush_o;
  endproperty
  a_auto_start: assert property (p_auto_start) // [RULE6]
    else $error("auto start did not flush once");

  property p_tx_retry;
    s_tx_retry |=> !r.err & flush_o & (r.st == EDE_TX_DMA);
  endproperty
  a_tx_retry: assert property (p_tx_retry) // [RULE21]
    else $error("retry with budget left raised error");

  property p_drain_halt;
    s_drain_end |=> (r.st == EDE_IDLE) & r.halt & !r.drain;
  endproperty
  a_drain_halt: assert property (p_drain_halt) // [RULE16]
    else $error("drain did not end idle with halt");

  property p_fifo_access_halt;
    (r.en & ep_evt_i.fifo_acc) |=> r.halt & !r.en ##1 !dma_req_o;
  endproperty
  a_fifo_access_halt: assert property (p_fifo_access_halt) // [RULE18]
    else $error("fifo access did not halt dma");

  property p_tx_fetch_req;
    ((r.st == EDE_TX_DMA) & r.en & sel_ok) |=> dma_req_o;
  endproperty
  a_tx_fetch_req: assert property (p_tx_fetch_req) // [RULE9]
    else $error("no request while fetching transmit packet");

endmodule

`default_nettype wire

// *** testbench/ede_dma_model.sv ***
// dma controller model answering the block's request line
`timescale 1ns/1ps
`default_nettype none

module ede_dma_model (
  // clock and reset
  input  wire logic       clk_sys_i,
  input  wire logic       srst_i,
  // answer delay in cycles
  input  wire logic [3:0] lat_i,
  // request and answer
  input  wire logic       dma_req_i,
  output logic            dma_done_o
);
  // ----------------------------------------------------------------
  // one packet per request
  // ----------------------------------------------------------------
  int cnt;

  // three idle cycles after each answer let the request fall first
  always_ff @(posedge clk_sys_i) begin
    dma_done_o <= 1'b0;
    if (srst_i) begin
      cnt <= 0;
    end else if (cnt > 0) begin
      cnt <= cnt - 1;
      if (cnt == 4) begin
        dma_done_o <= 1'b1;
      end
    end else if (dma_req_i) begin
      cnt <= int'(lat_i) + 4;
    end
  end
endmodule

`default_nettype wire

// *** testbench/tb_top.sv ***
// self-checking bench for the endpoint auto-dma block
`timescale 1ns/1ps
`default_nettype none

module tb_top;
  import ede_pkg::*;
  // ----------------------------------------------------------------
  // signals and models
  // ----------------------------------------------------------------
  logic        clk_sys_i, srst_i, mode_pin, dn;
  logic [3:0]  lat, event_flags_o;
  logic [7:0]  rdata_o;
  logic        flush_o, ep_auto_enable_o, rx_enable_o, tx_enable_o;
  logic        next_toggle_state_o, dma_req_o;
  ede_bus_t    bus;
  ede_ep_lvl_t lvl;
  ede_ep_evt_t evt, evt_m, e;
  int          fail_count, check_count, seed, ntg, pc, i, s, k;

  always_comb begin
    evt_m = evt;
    evt_m.dma_done = dn;
  end

  ede_auto_dma u_dut (
    .clk_sys_i            (clk_sys_i),
    .srst_i               (srst_i),
    .bus_i                (bus),
    .rdata_o              (rdata_o),
    .ep_lvl_i             (lvl),
    .ep_evt_i             (evt_m),
    .interface_mode_pin_i (mode_pin),
    .flush_o              (flush_o),
    .ep_auto_enable_o     (ep_auto_enable_o),
    .rx_enable_o          (rx_enable_o),
    .tx_enable_o          (tx_enable_o),
    .next_toggle_state_o  (next_toggle_state_o),
    .event_flags_o        (event_flags_o),
    .dma_req_o            (dma_req_o)
  );

  ede_dma_model u_dma (
    .clk_sys_i  (clk_sys_i),
    .srst_i     (srst_i),
    .lat_i      (lat),
    .dma_req_i  (dma_req_o),
    .dma_done_o (dn)
  );

  // ----------------------------------------------------------------
  // clock, watchdog and shared tasks
  // ----------------------------------------------------------------
  initial begin
    clk_sys_i = 1'b0;
    forever #4 clk_sys_i = ~clk_sys_i;
  end

  initial begin
    repeat (30000) @(posedge clk_sys_i);
    fail_count++;
    stop_test();
  end

  task stop_test;
    if (fail_count == 0 && check_count > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask

  task chk(input logic [7:0] g, input logic [7:0] x, input string m);
    check_count++;
    if (g !== x) begin
      fail_count++;
      $display("MISMATCH %0t %s", $time, m);
    end
  endtask

  task chb(input logic g, input logic x, input string m);
    chk({7'h00, g}, {7'h00, x}, m);
  endtask

  task wr(input logic [1:0] a, input logic [7:0] v);
    @(posedge clk_sys_i);
    bus <= '{addr: a, wdata: v, wr: 1'b1, rd: 1'b0};
    @(posedge clk_sys_i);
    bus.wr <= 1'b0;
    #1;
  endtask

  task rdc(input logic [1:0] a, input logic [7:0] x, input string m);
    @(posedge clk_sys_i);
    bus <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
    @(posedge clk_sys_i);
    bus.rd <= 1'b0;
    #1 chk(rdata_o, x, m);
  endtask

  task pulse(input ede_ep_evt_t p);
    @(posedge clk_sys_i);
    evt <= p;
    @(posedge clk_sys_i);
    evt <= '0;
    #1;
  endtask

  // bounded wait: 0 request, 1 receive enable, 2 transmit enable
  task till(input int w);
    logic [2:0] v;
    for (int n = 0; n < 40; n++) begin
      v = {tx_enable_o, rx_enable_o, dma_req_o};
      if (v[w] === 1'b1) break;
      @(posedge clk_sys_i);
      #1;
    end
  endtask

  task settle(input int c);
    repeat (c) @(posedge clk_sys_i);
    #1;
  endtask

  // enable and events must be clear before automatic mode starts
  task start_auto(input logic [7:0] c);
    wr(EDE_OFS_CTRL, 8'h00);
    wr(EDE_OFS_EVT, 8'h0F);
    wr(EDE_OFS_CTRL, c | 8'h10);
    chb(flush_o, 1'b1, "fifo flush");
    chb(ep_auto_enable_o, 1'b1, "endpoint enable");
    wr(EDE_OFS_CTRL, c | 8'h90);
  endtask

  // ----------------------------------------------------------------
  // scenarios
  // ----------------------------------------------------------------
  initial begin
    seed = 4;
    fail_count = 0;
    check_count = 0;
    srst_i = 1'b1;
    mode_pin = 1'b0;
    bus = '0;
    lvl = '0;
    evt = '0;
    lat = 4'h0;
    repeat (6) @(posedge clk_sys_i);
    srst_i <= 1'b0;
    for (k = 0; k < 4; k++) rdc(k[1:0], 8'h00, "reset value");
    s = $unsigned($random(seed)) % 8;
    for (k = 0; k < 8; k++) begin
      s = (s + 1) % 8;
      wr(EDE_OFS_CTRL, {5'h10, s[2:0]});
      lvl.tx_done <= 6'h3F;
      lvl.rx_last <= 6'h3F;
      settle(3);
      chb(dma_req_o, s < 6, "completion request");
      if (s < 2) pulse('{stat_rd: 1'b1, default: 1'b0});
      else if (s[0]) lvl.empty <= 6'h3F;
      else pulse('{txlast_set: 1'b1, default: 1'b0});
      settle(3);
      chb(dma_req_o, 1'b0, "request release");
      lvl <= '0;
    end
    s = $unsigned($random(seed)) % 6;
    wr(EDE_OFS_CTRL, {5'h11, s[2:0]});
    lvl.warn <= 6'h3F;
    settle(3);
    chb(dma_req_o, 1'b1, "warning request");
    lvl.warn <= 6'h00;
    settle(3);
    chb(dma_req_o, 1'b0, "warning release");
    wr(EDE_OFS_CTRL, 8'h00);
    mode_pin <= 1'b1;
    settle(4);
    wr(EDE_OFS_CTRL, 8'h80);
    rdc(EDE_OFS_CTRL, 8'h00, "enable in serial mode");
    mode_pin <= 1'b0;
    settle(4);
    wr(EDE_OFS_CTRL, 8'h20);
    chb(next_toggle_state_o, 1'b1, "toggle load");
    rdc(EDE_OFS_EVT, 8'h21, "toggle event bit");
    // two received packets, the second one ends on the count flag
    wr(EDE_OFS_CNT, 8'h01);
    pc = 1;
    ntg = 0;
    start_auto(8'h01);
    till(1);
    chb(rx_enable_o, 1'b1, "receive enable");
    for (k = 0; k < 2; k++) begin
      pulse('{pkt_done: 1'b1, pkt_tgl: ntg[0], default: 1'b0});
      ntg = 1 - ntg;
      chb(next_toggle_state_o, ntg[0], "toggle flip");
      lvl.rx_last <= 6'h02;
      till(0);
      chb(dma_req_o, 1'b1, "receive request");
      for (i = 0; i < 40 && dn !== 1'b1; i++) @(posedge clk_sys_i);
      settle(3);
      lvl.rx_last <= 6'h00;
      if (pc > 0) begin
        pc--;
        rdc(EDE_OFS_CNT, pc[7:0], "packet count");
      end else begin
        chk({4'h0, event_flags_o}, 8'h04, "count done");
        chb(ep_auto_enable_o, 1'b0, "auto end on event");
      end
    end
    for (k = 0; k < 2; k++) begin
      start_auto(k == 0 ? 8'h01 : 8'h41);
      till(1);
      pulse('{pkt_done: 1'b1, pkt_tgl: 1'b1, default: 1'b0});
      settle(2);
      chk({4'h0, event_flags_o}, k == 0 ? 8'h02 : 8'h00, "toggle check");
      chb(ep_auto_enable_o, k[0], "auto after mismatch");
    end
    start_auto(8'h01);
    till(1);
    wr(EDE_OFS_CTRL, 8'h81);
    settle(2);
    chk({4'h0, event_flags_o}, 8'h01, "halt after drain");
    chb(rx_enable_o, 1'b0, "receiver stopped");
    // retry under error handling, then a short packet finished in drain
    wr(EDE_OFS_ERR, 8'h81);
    wr(EDE_OFS_CNT, 8'h05);
    rdc(EDE_OFS_ERR, 8'h81, "error preset");
    start_auto(8'h01);
    till(1);
    pulse('{pkt_done: 1'b1, pkt_err: 1'b1, default: 1'b0});
    chb(flush_o, 1'b1, "receive retry");
    rdc(EDE_OFS_ERR, 8'h80, "retry budget");
    lvl.rx_last <= 6'h02;
    pulse('{pkt_done: 1'b1, pkt_short: 1'b1, default: 1'b0});
    wr(EDE_OFS_CTRL, 8'h81);
    for (i = 0; i < 40 && dn !== 1'b1; i++) @(posedge clk_sys_i);
    settle(3);
    lvl.rx_last <= 6'h00;
    chk({4'h0, event_flags_o}, 8'h09, "short after drain");
    rdc(EDE_OFS_CNT, 8'h04, "count after drain");
    for (k = 0; k < 3; k++) begin
      lat <= 4'($random(seed));
      start_auto(8'h00);
      till(0);
      chb(dma_req_o, 1'b1, "transmit fetch");
      till(2);
      chb(tx_enable_o, 1'b1, "transmit enable");
      if (k == 0) begin
        pulse('{pkt_done: 1'b1, pkt_err: 1'b1, default: 1'b0});
        chb(flush_o, 1'b1, "transmit retry");
        till(2);
      end
      e = '0;
      e.fifo_acc = (k == 1);
      e.reg_acc = (k == 2);
      if (k == 0) wr(EDE_OFS_CTRL, 8'h10);
      else pulse(e);
      settle(1);
      chk({4'h0, event_flags_o}, 8'h01, "software halt");
      chb(tx_enable_o | dma_req_o, 1'b0, "dma stopped");
    end
    rdc(EDE_OFS_EVT, 8'h01, "halt event read");
    wr(EDE_OFS_EVT, 8'h01);
    rdc(EDE_OFS_EVT, 8'h00, "event clear");
    stop_test();
  end
endmodule

`default_nettype wire
